// ==== src/datacomm_regs.vh ====
// Purpose: register map, field positions and codes of the datacomm register bank
// Assumes: byte addresses are four times the register number
// Notes: definitions only
`ifndef DATACOMM_REGS_VH
`define DATACOMM_REGS_VH
`define REG_ID        4'h0
`define REG_IRQ_EN    4'h1
`define REG_ACTIVITY  4'h2
`define REG_PROTOCOL  4'h3
`define REG_IRQ_STATE 4'h4
`define REG_INQ       4'h5
`define REG_BREAK     4'h6
`define REG_MODEM_IN  4'h7
`define REG_MODEM_OUT 4'h8
`define REG_CB_TYPE   4'h9
`define REG_CB_MODE   4'hA
`define REG_OUT_SPACE 4'hB
`define REG_LAST      4'hB
`define REG_ERROR     4'hF
`define ERR_NONE      16'h0000
`define ERR_NO_REG    16'h0146
`define ERR_BAD_VALUE 16'h0147
`define PROTO_ASYNC   8'h01
`define PROTO_LINK    8'h02
`define CB_NONE       8'h00
`define CB_BREAK      8'hFA
`define CB_ERROR      8'hFB
`define CB_EOL        8'hFC
`define CB_PROMPT     8'hFD
`define CB_LINK_END   8'hFE
`define CB_MODE_ONE   8'h01
`define CB_MODE_ETX   8'h02
`define CB_MODE_BOTH  8'h03
`define CB_BYTES      8'h03
`define MODEM_OUT_W   6
`define MODEM_RTS     0
`define IN_DATA       0
`define IN_CB         1
`define ACT_IN        0
`define ACT_OUT       1
`define CB_EV_BREAK   3'h1
`define CB_EV_FRAME   3'h2
`define CB_EV_PARITY  3'h3
`define CB_EV_BOTH    3'h4
`define CB_EV_EOL     3'h5
`define CB_EV_PROMPT  3'h6
`define CB_EV_ETB     3'h1
`define CB_EV_ETX     3'h2
`define CB_EV_SEL     3'h3
`define PROTO_UNSET 8'h00
`define CARD_RESET_NONE 8'h00
`define STRAP_LINK 2'h2
`define STRAP_START 2'h0
`define STRAP_SETTLE 2'h2
`define STRAP_DONE 2'h3
`endif

// ==== src/pin_sync.v ====
// Purpose: two flip-flop synchroniser for a vector of pin levels
// Assumes: inputs are asynchronous levels
// Notes: first stage is read only by the second
`timescale 1ns/10ps
module pin_sync #(
  parameter W = 5
) (
  input wire hclk,
  input wire hresetn,
  input wire [W-1:0] pin,
  output reg [W-1:0] level
);
  reg [W-1:0] stage1;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= {W{1'b0}};
      level <= {W{1'b0}};
    end else begin
      stage1 <= pin;
      level <= stage1;
    end
  end
endmodule

// ==== src/control_block_coder.v ====
// Purpose: turns a received control block event into type and mode codes
// Assumes: event code and protocol are stable while strobe is high
// Notes: pure combinational
`timescale 1ns/10ps
`include "datacomm_regs.vh"
module control_block_coder (
  input wire link_mode,
  input wire [2:0] event_code,
  input wire [3:0] sel_mode,
  input wire underscore_replace,
  output reg valid,
  output reg [7:0] cb_type,
  output reg [7:0] cb_mode
);
  always @* begin
    valid = 1'b1;
    cb_type = `CB_NONE;
    cb_mode = `CB_NONE;
    if (link_mode) begin
      case (event_code)
        `CB_EV_ETB: begin
          cb_type = `CB_LINK_END;
          cb_mode = `CB_MODE_ONE;
        end
        `CB_EV_ETX: begin
          cb_type = `CB_LINK_END;
          cb_mode = `CB_MODE_ETX;
        end
        `CB_EV_SEL: begin
          cb_type = `CB_PROMPT;
          cb_mode = {4'h0, sel_mode};
        end
        default: valid = 1'b0;
      endcase
    end else begin
      case (event_code)
        `CB_EV_BREAK: begin
          cb_type = `CB_BREAK;
          cb_mode = `CB_MODE_ONE;
        end
        `CB_EV_FRAME: begin
          cb_type = `CB_ERROR;
          cb_mode = `CB_MODE_ONE;
          valid = !underscore_replace;
        end
        `CB_EV_PARITY: begin
          cb_type = `CB_ERROR;
          cb_mode = `CB_MODE_ETX;
          valid = !underscore_replace;
        end
        `CB_EV_BOTH: begin
          cb_type = `CB_ERROR;
          cb_mode = `CB_MODE_BOTH;
          valid = !underscore_replace;
        end
        `CB_EV_EOL: begin
          cb_type = `CB_EOL;
          cb_mode = `CB_MODE_ONE;
        end
        `CB_EV_PROMPT: begin
          cb_type = `CB_PROMPT;
          cb_mode = `CB_MODE_ONE;
        end
        default: valid = 1'b0;
      endcase
    end
  end
endmodule

// ==== src/datacomm_card_register_interface.v ====
// Purpose: AHB-Lite register bank of a serial datacomm card
// Assumes: single word transfers; datapath engines sit outside and use the strobes
// Notes: register n sits at byte address 4*n; register 15 holds the last error code
//
// Function
// - writes above 255 rejected, error 327
// - missing register number gives error 326
// - controls hold defaults after reset
// - register 0 returns card identification code
// - nonzero write to 0 resets card, flushes
// - register 1 shows interrupt enable
// - register 2 shows input/output activity bits
// - register 3 protocol, applied at next reset
// - register 5 encodes inbound queue content
// - link mode terminate sends ETX then EOT
// - async terminate turns half-duplex line around
// - register 6 shows pending break
// - any accepted write to 6 requests break
// - register 7 shows modem receiver lines
// - register 8 drives modem output lines
// - half-duplex RTS changes only by output or card reset
// - registers 9,10 give last control block
// - async control block type and mode codes
// - no error blocks when underscore replacing
// - link control block type and mode codes
// - type 253 mode bits coded
// - outbound space reported only at three blocks or more
`timescale 1ns/10ps
`include "datacomm_regs.vh"
module datacomm_card_register_interface #(
  parameter [7:0] ID_SWITCH_ON = 8'h5A,
  parameter [7:0] ID_SWITCH_OFF = 8'hA5,
  parameter [7:0] OUT_QUEUE_BYTES = 8'hFF
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire id_switch_on,
  input wire [1:0] protocol_switch,
  input wire half_duplex,
  input wire irq_enabled,
  input wire [7:0] irq_state,
  input wire input_busy,
  input wire output_busy,
  input wire [1:0] inq_content,
  input wire [7:0] out_queue_used,
  input wire [4:0] modem_in_pins,
  input wire cb_strobe,
  input wire [2:0] cb_event,
  input wire [3:0] cb_sel_mode,
  input wire underscore_replace,
  input wire output_rts,
  input wire break_done,
  output reg card_reset,
  output reg link_mode,
  output reg term_etx_eot,
  output reg term_turnaround,
  output reg break_send,
  output reg [`MODEM_OUT_W-1:0] modem_out
);
  reg ap_valid;
  reg ap_write;
  reg [3:0] ap_reg;
  reg ap_exists;
  reg [7:0] proto_next;
  reg break_pending;
  reg [7:0] cb_type;
  reg [7:0] cb_mode;
  reg [15:0] last_error;
  reg id_switch;
  reg [1:0] strap_wait;
  reg [31:0] read_mux;
  wire [4:0] modem_in;
  wire cb_valid;
  wire [7:0] cb_type_new;
  wire [7:0] cb_mode_new;
  wire wr;
  wire value_ok;
  wire [8:0] space_left;
  wire [2:0] strap_level;
  wire wr_ok;
  wire wr_reset;
  wire wr_proto;
  wire wr_term;
  wire wr_break;
  wire wr_modem;
  wire rd_start;

  // modem receive lines are asynchronous pins
  pin_sync #(.W(5)) modem_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(modem_in_pins),
    .level(modem_in)
  );

  // card switches are pins as well; read only after both stages have filled
  pin_sync #(.W(3)) strap_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin({id_switch_on, protocol_switch}),
    .level(strap_level)
  );

  control_block_coder coder (
    .link_mode(link_mode),
    .event_code(cb_event),
    .sel_mode(cb_sel_mode),
    .underscore_replace(underscore_replace),
    .valid(cb_valid),
    .cb_type(cb_type_new),
    .cb_mode(cb_mode_new)
  );

  function exists_reg;
    input [3:0] r;
    begin
      exists_reg = (r <= `REG_LAST) || (r == `REG_ERROR);
    end
  endfunction

  function writable_reg;
    input [3:0] r;
    begin
      writable_reg = (r == `REG_ID) || (r == `REG_PROTOCOL) || (r == `REG_INQ) ||
                     (r == `REG_BREAK) || (r == `REG_MODEM_OUT);
    end
  endfunction

  // only the two protocol codes may be requested
  function legal_proto;
    input [7:0] v;
    begin
      legal_proto = (v == `PROTO_ASYNC) || (v == `PROTO_LINK);
    end
  endfunction

  // address phase capture; writes take no wait state, reads one
  // an address held through a wait state is taken at the edge after it, when hready is high again
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_reg <= 4'h0;
      ap_exists <= 1'b0;
    end else if (hready) begin
      ap_valid <= hsel && htrans[1];
      ap_write <= hwrite;
      ap_reg <= haddr[5:2];
      ap_exists <= exists_reg(haddr[5:2]) && (haddr[31:6] == 26'h0);
    end else begin
      ap_valid <= 1'b0;
    end
  end

  assign wr = ap_valid && ap_write && ap_exists && writable_reg(ap_reg);
  assign value_ok = (hwdata[31:8] == 24'h0);
  // accepted writes, decoded once; the value range is checked for every one
  assign wr_ok = wr && value_ok;
  assign wr_reset = wr_ok && (ap_reg == `REG_ID) && (hwdata[7:0] != `CARD_RESET_NONE);
  assign wr_proto = wr_ok && (ap_reg == `REG_PROTOCOL) && legal_proto(hwdata[7:0]);
  assign wr_term = wr_ok && (ap_reg == `REG_INQ);
  assign wr_break = wr_ok && (ap_reg == `REG_BREAK);
  assign wr_modem = wr_ok && (ap_reg == `REG_MODEM_OUT);
  // a read gets one wait state so that its data stands in the data phase
  assign rd_start = hready && hsel && htrans[1] && !hwrite;
  assign space_left = {1'b0, OUT_QUEUE_BYTES} - {1'b0, out_queue_used};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      // one wait state for a read, none for a write
      hreadyout <= !rd_start;
      // every answer is okay; refusals show in the error register
      hresp <= 1'b0;
    end
  end

  // error code: last failing access; cleared by a read of the error register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_error <= `ERR_NONE;
    end else if (ap_valid && !ap_exists) begin
      last_error <= `ERR_NO_REG;
    end else if (ap_valid && ap_write && !writable_reg(ap_reg)) begin
      last_error <= `ERR_NO_REG;
    end else if (wr && !value_ok) begin
      last_error <= `ERR_BAD_VALUE;
    end else if (wr && ap_reg == `REG_PROTOCOL && !legal_proto(hwdata[7:0])) begin
      last_error <= `ERR_BAD_VALUE;
    end else if (ap_valid && !ap_write && ap_reg == `REG_ERROR) begin
      last_error <= `ERR_NONE;
    end
  end

  // card reset pulse; straps, break, drivers and last control block below restart from it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      card_reset <= 1'b0;
    end else begin
      // the engines flush their queues on this pulse
      card_reset <= wr_reset;
    end
  end

  // settle count: the strap synchroniser holds the switch levels two edges after release
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_wait <= `STRAP_START;
    end else if (strap_wait != `STRAP_DONE) begin
      strap_wait <= strap_wait + 2'h1;
    end
  end

  // switches are straps, caught once they have settled and again at card reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      id_switch <= 1'b1;
      link_mode <= 1'b0;
    end else if (strap_wait == `STRAP_SETTLE || card_reset) begin
      id_switch <= strap_level[2];
      if (proto_next != `PROTO_UNSET) begin
        link_mode <= (proto_next == `PROTO_LINK);
      end else begin
        link_mode <= (strap_level[1:0] == `STRAP_LINK);
      end
    end
  end

  // protocol request survives card reset so that it can take effect there
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      proto_next <= `PROTO_UNSET;
    end else if (wr_proto) begin
      proto_next <= hwdata[7:0];
    end
  end

  // terminate strobes; async full duplex has nothing to turn around
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      term_etx_eot <= 1'b0;
      term_turnaround <= 1'b0;
    end else begin
      term_etx_eot <= wr_term && link_mode;
      term_turnaround <= wr_term && !link_mode && half_duplex;
    end
  end

  // break strobe and pending flag; a request in the done cycle stays pending
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      break_send <= 1'b0;
      break_pending <= 1'b0;
    end else begin
      break_send <= wr_break;
      if (card_reset) begin
        break_pending <= 1'b0;
      end else if (wr_break) begin
        break_pending <= 1'b1;
      end else if (break_done) begin
        break_pending <= 1'b0;
      end
    end
  end

  // modem drivers; half-duplex RTS follows the output engine, not writes; card reset drops it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      modem_out <= {`MODEM_OUT_W{1'b0}};
    end else if (card_reset) begin
      // a card reset drops every driver; all but half-duplex RTS stay low until register 8 is written
      modem_out <= {`MODEM_OUT_W{1'b0}};
    end else begin
      if (wr_modem) begin
        modem_out <= hwdata[`MODEM_OUT_W-1:0];
      end
      if (half_duplex) begin
        modem_out[`MODEM_RTS] <= output_rts;
      end
    end
  end

  // last control block; cleared by card reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cb_type <= `CB_NONE;
      cb_mode <= `CB_NONE;
    end else if (card_reset) begin
      cb_type <= `CB_NONE;
      cb_mode <= `CB_NONE;
    end else if (cb_strobe && cb_valid) begin
      cb_type <= cb_type_new;
      cb_mode <= cb_mode_new;
    end
  end

  always @* begin
    read_mux = 32'h0000_0000;
    case (ap_reg)
      `REG_ID: read_mux[7:0] = id_switch ? ID_SWITCH_ON : ID_SWITCH_OFF;
      `REG_IRQ_EN: read_mux[0] = irq_enabled;
      `REG_ACTIVITY: read_mux[1:0] = {output_busy, input_busy};
      `REG_PROTOCOL: read_mux[7:0] = link_mode ? `PROTO_LINK : `PROTO_ASYNC;
      `REG_IRQ_STATE: read_mux[7:0] = irq_state;
      `REG_INQ: read_mux[1:0] = {inq_content[`IN_CB], inq_content[`IN_DATA]};
      `REG_BREAK: read_mux[0] = break_pending;
      `REG_MODEM_IN: read_mux[4:0] = modem_in;
      `REG_MODEM_OUT: read_mux[`MODEM_OUT_W-1:0] = modem_out;
      `REG_CB_TYPE: read_mux[7:0] = cb_type;
      `REG_CB_MODE: read_mux[7:0] = cb_mode;
      `REG_OUT_SPACE: begin
        // room for three blocks is reckoned as three bytes; below that the space reads zero
        if (!space_left[8] && space_left[7:0] >= `CB_BYTES) begin
          read_mux[7:0] = space_left[7:0];
        end
      end
      `REG_ERROR: read_mux[15:0] = last_error;
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // read data is loaded at the end of the wait state and stands while hreadyout is high;
  // it is zeroed when a read is taken, so a refused read returns zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_start) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_valid && !ap_write && ap_exists) begin
      hrdata <= read_mux;
    end
  end
endmodule

// ==== tb/dcri_sva.sv ====
// Purpose: port-level checker for the datacomm register bank
// Assumes: hready is the bank's own hreadyout
// Notes: bound at the foot of this file
`timescale 1ns/10ps
`include "datacomm_regs.vh"
module dcri_sva (
  input wire hclk,
  input wire hresetn,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire half_duplex,
  input wire output_rts,
  input wire card_reset,
  input wire link_mode,
  input wire term_etx_eot,
  input wire term_turnaround,
  input wire break_send,
  input wire [`MODEM_OUT_W-1:0] modem_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_okay_resp: assert property (!hresp)
    else $error("bus answer not okay");
  a_one_wait: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  a_byte_wide: assert property (hrdata[31:8] == 24'h000000 || hrdata == {16'h0000, `ERR_NO_REG}
    || hrdata == {16'h0000, `ERR_BAD_VALUE})
    else $error("read data above bit 7");
  a_reset_pulse: assert property (card_reset |=> !card_reset)
    else $error("card reset longer than one cycle");
  a_proto_at_reset: assert property ($changed(link_mode) |-> card_reset || $past(card_reset)
    || $past(card_reset, 2) || !$past(hresetn) || !$past(hresetn, 2) || !$past(hresetn, 4))
    else $error("protocol changed without reset");
  a_etx_link: assert property (term_etx_eot |-> link_mode && !term_turnaround)
    else $error("block end outside link protocol");
  a_turn_half: assert property (term_turnaround |-> !link_mode && half_duplex)
    else $error("turnaround outside async half duplex");
  a_break_pulse: assert property (break_send |=> !break_send)
    else $error("break request longer than one cycle");
  a_rts_output: assert property ((half_duplex && $stable(output_rts))[*3]
    |-> modem_out[`MODEM_RTS] == output_rts)
    else $error("half duplex rts not from output");
  a_reset_clear: assert property ($rose(hresetn) |-> modem_out == 6'h00 && !break_send)
    else $error("drivers not cleared by reset");
endmodule
bind datacomm_card_register_interface dcri_sva dcri_sva_i (.hclk, .hresetn, .hrdata, .hreadyout,
  .hresp, .half_duplex, .output_rts, .card_reset, .link_mode, .term_etx_eot, .term_turnaround,
  .break_send, .modem_out);

// ==== tb/modem_far_end.sv ====
// Purpose: modem at the far side of the driver and receiver lines
// Assumes: clear-to-send answers request-to-send after a lag
// Notes: slow stretches the lag to eight cycles
`timescale 1ns/10ps
module modem_far_end (
  input wire hclk,
  input wire slow,
  input wire ring,
  input wire [5:0] modem_out,
  output logic [4:0] modem_in_pins
);
  logic [7:0] rts_hist = 8'h00;
  always @(posedge hclk) rts_hist <= {rts_hist[6:0], modem_out[0]};
  // data set ready and carrier follow terminal ready; bit 4 loops driver 3 back
  assign modem_in_pins = {modem_out[3], ring, slow ? rts_hist[7] : rts_hist[0], modem_out[1], modem_out[1]};
endmodule

// ==== tb/tb.sv ====
// Purpose: register-level test of the datacomm register bank
// Assumes: reads take one wait state, writes none
// Notes: register n at byte address 4*n
`timescale 1ns/10ps
`include "datacomm_regs.vh"
module tb;
  localparam [7:0] ID_ON = 8'h3C; // arbitrary identity value
  localparam [7:0] ID_OFF = 8'hC3; // arbitrary identity value
  localparam [7:0] QB = 8'hFF;
  logic hclk = 0, hresetn = 0, hwrite = 0, id_switch_on = 1, half_duplex = 0, irq_enabled = 0;
  logic input_busy = 0, output_busy = 0, cb_strobe = 0, underscore_replace = 0;
  logic output_rts = 0, break_done = 0, slow = 0, ring = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd_val;
  logic [1:0] htrans = 0, protocol_switch = 0, inq_content = 0;
  logic [7:0] out_queue_used = 0;
  logic [2:0] cb_event = 0;
  logic [3:0] cb_sel_mode = 0;
  wire hready, hresp, card_reset, link_mode, term_etx_eot, term_turnaround, break_send;
  wire [31:0] hrdata;
  wire [4:0] modem_in_pins;
  wire [5:0] modem_out;
  int n_fail = 0, check_count = 0, cyc = 0, n_etx = 0, n_turn = 0, n_brk = 0, n_rst = 0;
  datacomm_card_register_interface #(.ID_SWITCH_ON(ID_ON), .ID_SWITCH_OFF(ID_OFF), .OUT_QUEUE_BYTES(QB))
    datacomm_card_register_interface_i (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .id_switch_on,
    .protocol_switch, .half_duplex, .irq_enabled, .irq_state(8'h00), .input_busy, .output_busy,
    .inq_content, .out_queue_used, .modem_in_pins, .cb_strobe, .cb_event, .cb_sel_mode,
    .underscore_replace, .output_rts, .break_done, .card_reset, .link_mode, .term_etx_eot,
    .term_turnaround, .break_send, .modem_out);
  modem_far_end modem_far_end_i (.hclk, .slow, .ring, .modem_out, .modem_in_pins);
  always #2 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    n_etx += term_etx_eot;
    n_turn += term_turnaround;
    n_brk += break_send;
    n_rst += card_reset;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task xfer(input logic w, input logic [3:0] r, input logic [31:0] v);
    haddr <= {26'h0, r, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= v;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    rd_val = hrdata;
  endtask
  task rc(input string n, input logic [3:0] r, input logic [31:0] e);
    xfer(1'b0, r, 32'h0);
    chk(n, rd_val, e);
  endtask
  task cb(input logic [2:0] e, input logic [3:0] s, input logic [15:0] tm);
    cb_event <= e;
    cb_sel_mode <= s;
    cb_strobe <= 1;
    @(posedge hclk);
    cb_strobe <= 0;
    @(posedge hclk);
    rc("cb type", `REG_CB_TYPE, tm[15:8]);
    rc("cb mode", `REG_CB_MODE, tm[7:0]);
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    repeat (2) @(posedge hclk);
    rc("ident", `REG_ID, ID_ON);
    rc("drivers", `REG_MODEM_OUT, 32'h0);
    rc("cb none", `REG_CB_TYPE, 32'h0);
    rc("protocol", `REG_PROTOCOL, 32'h1);
    irq_enabled <= 1;
    rc("irq on", `REG_IRQ_EN, 32'h1);
    irq_enabled <= 0;
    rc("irq off", `REG_IRQ_EN, 32'h0);
    for (int i = 0; i < 4; i++) begin
      {output_busy, input_busy} <= i[1:0];
      inq_content <= i[1:0];
      rc("activity", `REG_ACTIVITY, i);
      rc("inbound", `REG_INQ, i);
    end
    $display("test status done");
    xfer(1'b1, `REG_MODEM_OUT, 32'h100);
    rc("bad value", `REG_ERROR, 32'h147);
    rc("kept", `REG_MODEM_OUT, 32'h0);
    rc("no reg", 4'hC, 32'h0);
    rc("no reg err", `REG_ERROR, 32'h146);
    xfer(1'b1, `REG_MODEM_IN, 32'h1);
    rc("ro write", `REG_ERROR, 32'h146);
    xfer(1'b1, `REG_PROTOCOL, 32'h3);
    rc("bad proto", `REG_ERROR, 32'h147);
    $display("test refusals done");
    slow <= 1;
    xfer(1'b1, `REG_MODEM_OUT, 32'h0B);
    repeat (12) @(posedge hclk);
    rc("drivers set", `REG_MODEM_OUT, 32'h0B);
    rc("receivers", `REG_MODEM_IN, 32'h17);
    ring <= 1;
    repeat (4) @(posedge hclk);
    rc("ring", `REG_MODEM_IN, 32'h1F);
    xfer(1'b1, `REG_MODEM_OUT, 32'hC0);
    rc("unused bits", `REG_MODEM_OUT, 32'h0);
    half_duplex <= 1;
    output_rts <= 1;
    xfer(1'b1, `REG_MODEM_OUT, 32'h02);
    rc("rts held", `REG_MODEM_OUT, 32'h03);
    output_rts <= 0;
    rc("rts follows", `REG_MODEM_OUT, 32'h02);
    xfer(1'b1, `REG_INQ, 32'h0);
    repeat (2) @(posedge hclk);
    half_duplex <= 0;
    xfer(1'b1, `REG_INQ, 32'h0);
    chk("turnaround", n_turn, 1);
    chk("no block end", n_etx, 0);
    xfer(1'b1, `REG_BREAK, 32'h5A);
    rc("break pend", `REG_BREAK, 32'h1);
    chk("break sent", n_brk, 1);
    break_done <= 1;
    @(posedge hclk);
    break_done <= 0;
    rc("break idle", `REG_BREAK, 32'h0);
    $display("test lines done");
    cb(3'h1, 4'h0, 16'hFA01);
    cb(3'h2, 4'h0, 16'hFB01);
    cb(3'h3, 4'h0, 16'hFB02);
    cb(3'h4, 4'h0, 16'hFB03);
    cb(3'h5, 4'h0, 16'hFC01);
    cb(3'h6, 4'h0, 16'hFD01);
    underscore_replace <= 1;
    cb(3'h4, 4'h0, 16'hFD01);
    underscore_replace <= 0;
    xfer(1'b1, `REG_PROTOCOL, 32'h2);
    rc("proto kept", `REG_PROTOCOL, 32'h1);
    id_switch_on <= 0;
    xfer(1'b1, `REG_ID, 32'h0);
    chk("zero no reset", n_rst, 0);
    xfer(1'b1, `REG_ID, 32'hFF);
    repeat (3) @(posedge hclk);
    chk("reset", n_rst, 1);
    rc("proto new", `REG_PROTOCOL, 32'h2);
    rc("ident off", `REG_ID, ID_OFF);
    rc("drivers reset", `REG_MODEM_OUT, 32'h0);
    cb(3'h1, 4'h0, 16'hFE01);
    cb(3'h2, 4'h0, 16'hFE02);
    cb(3'h3, 4'hB, 16'hFD0B);
    cb(3'h3, 4'h4, 16'hFD04);
    xfer(1'b1, `REG_INQ, 32'h0);
    repeat (2) @(posedge hclk);
    chk("block end", n_etx, 1);
    $display("test protocol done");
    out_queue_used <= 8'h10;
    rc("space", `REG_OUT_SPACE, QB - 8'h10);
    out_queue_used <= QB - 8'h03;
    rc("space edge", `REG_OUT_SPACE, 32'h03);
    out_queue_used <= QB - 8'h02;
    rc("space none", `REG_OUT_SPACE, 32'h0);
    $display("test space done");
    complete_run();
  end
endmodule
